//--- common/scr_defines.svh
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// register map (word index on the device's internal register port)
`define SCR_SETUP_OFFSET      4'h1
`define SCR_SETUP_RESET       16'h0000

// field positions
`define SCR_ANGLE_HI          15
`define SCR_ANGLE_LO          14
`define SCR_INTERVAL_HI       13
`define SCR_INTERVAL_LO       10
`define SCR_CHAN_HI           9
`define SCR_CHAN_LO           6
`define SCR_ZRANGE_HI         5
`define SCR_ZRANGE_LO         4
`define SCR_YRANGE_HI         3
`define SCR_YRANGE_LO         2
`define SCR_XRANGE_HI         1
`define SCR_XRANGE_LO         0

// unused-code limits and fallbacks
`define SCR_INTERVAL_MAX      4'h9
`define SCR_INTERVAL_DEFAULT  4'h0
`define SCR_RANGE_LAST        2'h2
`define SCR_RANGE_DEFAULT     2'h0
`define SCR_CHAN_SEQ_FIRST    4'h8

// power state code in which the dwell applies
`define SCR_PWR_DUTY          3'h2

// dwell figures in milliseconds and cycles at 10 MHz
`define SCR_CLK_HZ            10000000
`define SCR_MS_CYCLES         (`SCR_CLK_HZ / 1000)

`endif

//--- common/scr_pkg.sv
package scr_pkg;

	typedef struct packed {
		logic [1:0] angle_pair;
		logic [3:0] low_power_interval;
		logic [3:0] axis_channel_select;
		logic [1:0] z_range;
		logic [1:0] y_range;
		logic [1:0] x_range;
	} scr_setup_t;

	// register port request from the serial front end
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} scr_req_t;

	// decoded view handed to the conversion logic
	typedef struct packed {
		logic        angle_on;
		logic [2:0]  angle_axes;        // bit0 x, bit1 y, bit2 z
		logic        dwell_active;
		logic [23:0] dwell_cycles;
		logic [2:0]  seq_len;
		logic [11:0] seq_axes;          // six 2-bit slots, 1=x 2=y 3=z, 0=none
	} scr_cfg_t;

	typedef struct packed {
		scr_setup_t  setup;
		logic [15:0] rdata;
		logic        rvalid;
		scr_cfg_t    cfg;
	} scr_state_t;

endpackage

//--- hw/scr_sensor_setup.sv
`timescale 1ns/1ps
`include "scr_defines.svh"
// How it works
// - setup register lives at index one, resets to zero, read/write with unused dwell and range codes folded.
// - bits 15:14 pick angle pair: off, X-Y, Y-Z, X-Z.
// - bits 13:10 pick dwell 1..1000 ms, used only in power state 010b.
// - dwell codes 0xA to 0xF act as code zero, one millisecond.
// - bits 9:6 pick axis channels; zero turns every channel off.
// - channel codes 1 to 7 are a mask: bit0 X, bit1 Y, bit2 Z.
// - channel codes 8 to 15 run XYX, YXY, YZY, ZYZ, ZXZ, XZX, XYZYX, XYZZYX.
// - two-bit ranges per axis: Z at 5:4, Y at 3:2, X at 1:0.
// - range 0 default mid scale, 1 low scale, 2 high scale.
// - range code 3 is replaced by range code zero.
// - power state code 2 is the duty-cycled state; others are other states.
module scr_sensor_setup
	import scr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire scr_req_t    req,
	input  wire logic [2:0]  power_state,
	output logic [15:0]      rdata,
	output logic             rvalid,
	output scr_setup_t       setup,
	output scr_cfg_t         cfg
);

	scr_state_t state;
	scr_state_t next_state;

	// the dwell and range fields pass their own fold, so unused codes never reach storage
	logic [3:0] fold_interval;
	logic [1:0] fold_zrange;
	logic [1:0] fold_yrange;
	logic [1:0] fold_xrange;

	// dwell codes past nine run as the one millisecond setting
	scr_code_fold
	#(
		.WIDTH        (4),
		.LAST_USED    (`SCR_INTERVAL_MAX),
		.DEFAULT_CODE (`SCR_INTERVAL_DEFAULT)
	)
	i_fold_interval
	(
		.code   (req.wdata[`SCR_INTERVAL_HI:`SCR_INTERVAL_LO]),
		.folded (fold_interval)
	);

	// z range, code 3 falls back to the default scale
	scr_code_fold
	#(
		.WIDTH        (2),
		.LAST_USED    (`SCR_RANGE_LAST),
		.DEFAULT_CODE (`SCR_RANGE_DEFAULT)
	)
	i_fold_zrange
	(
		.code   (req.wdata[`SCR_ZRANGE_HI:`SCR_ZRANGE_LO]),
		.folded (fold_zrange)
	);

	// y range, same fold as z
	scr_code_fold
	#(
		.WIDTH        (2),
		.LAST_USED    (`SCR_RANGE_LAST),
		.DEFAULT_CODE (`SCR_RANGE_DEFAULT)
	)
	i_fold_yrange
	(
		.code   (req.wdata[`SCR_YRANGE_HI:`SCR_YRANGE_LO]),
		.folded (fold_yrange)
	);

	// x range, same fold as z
	scr_code_fold
	#(
		.WIDTH        (2),
		.LAST_USED    (`SCR_RANGE_LAST),
		.DEFAULT_CODE (`SCR_RANGE_DEFAULT)
	)
	i_fold_xrange
	(
		.code   (req.wdata[`SCR_XRANGE_HI:`SCR_XRANGE_LO]),
		.folded (fold_xrange)
	);

	// dwell code to cycle count, one ms unit times the printed figure
	function automatic logic [23:0] dwell_of(input logic [3:0] code);
		logic [31:0] ms;
		ms = 32'd1;
		case (code)
			4'h0:    ms = 32'd1;
			4'h1:    ms = 32'd5;
			4'h2:    ms = 32'd10;
			4'h3:    ms = 32'd15;
			4'h4:    ms = 32'd20;
			4'h5:    ms = 32'd30;
			4'h6:    ms = 32'd50;
			4'h7:    ms = 32'd100;
			4'h8:    ms = 32'd500;
			4'h9:    ms = 32'd1000;
			default: ms = 32'd1;
		endcase
		dwell_of = 24'(ms * `SCR_MS_CYCLES);
	endfunction

	// sequence table, slots packed from slot 0 upward (1=x 2=y 3=z)
	function automatic logic [14:0] seq_of(input logic [3:0] code);
		logic [14:0] r;
		r = 15'h0000;
		case (code)
			4'h8:    r = {3'd3, 12'b00_00_00_01_10_01};  // xyx
			4'h9:    r = {3'd3, 12'b00_00_00_10_01_10};  // yxy
			4'ha:    r = {3'd3, 12'b00_00_00_10_11_10};  // yzy
			4'hb:    r = {3'd3, 12'b00_00_00_11_10_11};  // zyz
			4'hc:    r = {3'd3, 12'b00_00_00_11_01_11};  // zxz
			4'hd:    r = {3'd3, 12'b00_00_00_01_11_01};  // xzx
			4'he:    r = {3'd5, 12'b00_01_10_11_10_01};  // xyzyx
			4'hf:    r = {3'd6, 12'b01_10_11_11_10_01};  // xyzzyx
			default: r = 15'h0000;
		endcase
		seq_of = r;
	endfunction

	// mask codes enumerate enabled axes in x, y, z order
	function automatic logic [14:0] mask_seq(input logic [2:0] m);
		logic [11:0] s;
		logic [2:0]  n;
		s = 12'h000;
		n = 3'd0;
		for (int i = 0; i < 3; i++)
		begin
			if (m[i])
			begin
				s[n*2 +: 2] = 2'(i + 1);
				n = n + 3'd1;
			end
		end
		mask_seq = {n, s};
	endfunction

	// write filtering, register read port and decoded configuration
	always_comb
	begin
		logic [15:0] w;
		logic [14:0] sq;
		w = req.wdata;
		sq = 15'h0000;
		next_state = state;
		next_state.rvalid = 1'b0;
		if (req.wr && req.addr == `SCR_SETUP_OFFSET)
		begin
			next_state.setup.angle_pair = w[`SCR_ANGLE_HI:`SCR_ANGLE_LO];
			next_state.setup.low_power_interval = fold_interval;
			next_state.setup.axis_channel_select = w[`SCR_CHAN_HI:`SCR_CHAN_LO];
			// ranges arrive folded, so code 3 is never stored nor read back
			next_state.setup.z_range = fold_zrange;
			next_state.setup.y_range = fold_yrange;
			next_state.setup.x_range = fold_xrange;
		end
		// reads return the filtered contents, so a read after writing an unused code sees the default
		if (req.rd)
		begin
			next_state.rvalid = 1'b1;
			next_state.rdata = (req.addr == `SCR_SETUP_OFFSET) ? 16'(state.setup) : 16'h0000;
		end
		// decoded view follows the stored value, and dwell_active the power state, one cycle later
		next_state.cfg.angle_on = (state.setup.angle_pair != 2'h0);
		case (state.setup.angle_pair)
			2'h1:    next_state.cfg.angle_axes = 3'b011;
			2'h2:    next_state.cfg.angle_axes = 3'b110;
			2'h3:    next_state.cfg.angle_axes = 3'b101;
			default: next_state.cfg.angle_axes = 3'b000;
		endcase
		// dwell only steers the sequencer in the duty-cycled power state
		next_state.cfg.dwell_active = (power_state == `SCR_PWR_DUTY);
		next_state.cfg.dwell_cycles = dwell_of(state.setup.low_power_interval);
		if (state.setup.axis_channel_select >= `SCR_CHAN_SEQ_FIRST)
			sq = seq_of(state.setup.axis_channel_select);
		else
			sq = mask_seq(state.setup.axis_channel_select[2:0]);
		next_state.cfg.seq_len = sq[14:12];
		next_state.cfg.seq_axes = sq[11:0];
		if (srst)
		begin
			next_state = '0;
			next_state.setup = scr_setup_t'(`SCR_SETUP_RESET);
			next_state.cfg.dwell_cycles = 24'(`SCR_MS_CYCLES);
		end
	end

	// single state register, reset handled synchronously above
	always_ff @(posedge clk_sys)
	begin
		state <= next_state;
	end

	assign rdata = state.rdata;
	assign rvalid = state.rvalid;
	assign setup = state.setup;
	assign cfg = state.cfg;

endmodule

// folds every unused code of a field onto its default before it is stored,
// so the value read back is the one the conversion logic acts on;
// purely combinational, the caller's register holds the result
module scr_code_fold
	import scr_pkg::*;
#(
	parameter int unsigned      WIDTH        = 2,
	parameter logic [WIDTH-1:0] LAST_USED    = 2'h2,
	parameter logic [WIDTH-1:0] DEFAULT_CODE = 2'h0
)
(
	input  wire logic [WIDTH-1:0] code,
	output logic [WIDTH-1:0]      folded
);

	// unused codes sit above the last used one; a compare is cheaper than a table
	assign folded = (code > LAST_USED) ? DEFAULT_CODE : code;

endmodule

//--- tb/scr_host_model.sv
`timescale 1ns/1ps
module scr_host_model
	import scr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rvalid,
	input  wire logic [15:0] rdata,
	output scr_req_t         req
);
	initial req = '0;
	// idle data is the inverse of the last word, so a stale bus never passes for live data
	task automatic wr(input logic [3:0] a, input logic [15:0] w);
		@(posedge clk_sys) #1 req = '{1'b1, 1'b0, a, w};
		@(posedge clk_sys) #1 req = '{1'b0, 1'b0, a, ~w};
	endtask
	// the answer lands on the edge that takes the strobe down
	task automatic rd(input logic [3:0] a, output logic v, output logic [15:0] r);
		@(posedge clk_sys) #1 req = '{1'b0, 1'b1, a, ~req.wdata};
		@(posedge clk_sys) #1 req.rd = 1'b0;
		v = rvalid;
		r = rdata;
	endtask
endmodule

//--- tb/scr_sensor_setup_checker.sv
`timescale 1ns/1ps
module scr_sensor_setup_checker
	import scr_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        srst,
	input wire scr_req_t    req,
	input wire logic [2:0]  power_state,
	input wire logic [15:0] rdata,
	input wire logic        rvalid,
	input wire scr_setup_t  setup,
	input wire scr_cfg_t    cfg
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	// a write aimed at the setup register
	wire wr1 = req.wr && req.addr == 4'h1;
	property p_rv; rvalid == $past(req.rd && !srst); endproperty
	a_rv: assert property (p_rv) else $error("rvalid");
	property p_rdat; req.rd && req.addr == 4'h1 |=> rdata == $past(setup); endproperty
	a_rdat: assert property (p_rdat) else $error("rdata");
	property p_ign; req.wr && req.addr != 4'h1 |=> $stable(setup); endproperty
	a_ign: assert property (p_ign) else $error("unmapped");
	property p_fld; wr1 |=> {setup.angle_pair, setup.axis_channel_select}
		== $past({req.wdata[15:14], req.wdata[9:6]}); endproperty
	a_fld: assert property (p_fld) else $error("fields");
	property p_dw; wr1 |=> setup.low_power_interval
		== ($past(req.wdata[13:10]) > 4'h9 ? 4'h0 : $past(req.wdata[13:10])); endproperty
	a_dw: assert property (p_dw) else $error("dwell");
	property p_rng; wr1 && req.wdata[5:4] == 2'h3 |=> setup.z_range == 2'h0; endproperty
	a_rng: assert property (p_rng) else $error("range");
	property p_seq; setup.axis_channel_select == 4'hf |=> cfg.seq_axes == 12'h6f9; endproperty
	a_seq: assert property (p_seq) else $error("seq");
	property p_dwa; power_state == 3'h2 |=> cfg.dwell_active; endproperty
	a_dwa: assert property (p_dwa) else $error("dwell_active");
endmodule
bind scr_sensor_setup scr_sensor_setup_checker i_chk (.clk_sys, .srst, .req,
	.power_state, .rdata, .rvalid, .setup, .cfg);

//--- tb/scr_sensor_setup_test.sv
`timescale 1ns/1ps
module scr_sensor_setup_test
	import scr_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic [2:0]  power_state = 3'h0;
	scr_req_t    req;
	logic [15:0] rdata, d;
	logic        rvalid, v;
	logic [1:0]  rr;
	scr_setup_t  setup;
	scr_cfg_t    cfg;
	int          errors = 0;
	int          total_checks = 0;
	int          ms [16] = '{1, 5, 10, 15, 20, 30, 50, 100, 500, 1000, 1, 1, 1, 1, 1, 1};
	// angle axes per pair code: bit0 x, bit1 y, bit2 z
	logic [2:0]  ax [4] = '{3'b000, 3'b011, 3'b110, 3'b101};
	// per channel code: slot count, then 2-bit axes from slot 0 (1=x 2=y 3=z)
	logic [14:0] sq [16] = '{15'h0000, 15'h1001, 15'h1002, 15'h2009, 15'h1003, 15'h200d,
		15'h200e, 15'h3039, 15'h3019, 15'h3026, 15'h302e, 15'h303b, 15'h3037, 15'h301d,
		15'h51b9, 15'h66f9};
	always #50 clk_sys = ~clk_sys;
	scr_sensor_setup i_dut (.clk_sys, .srst, .req, .power_state, .rdata, .rvalid, .setup, .cfg);
	scr_host_model i_host (.clk_sys, .rvalid, .rdata, .req);
	task automatic chk(string n, logic [23:0] s, logic [23:0] x);
		total_checks++;
		if (s !== x)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// a read must always answer, mapped or not
	task automatic rchk(logic [3:0] a, logic [15:0] x);
		i_host.rd(a, v, d);
		chk("rvalid", 24'(v), 24'h1);
		chk("rdata", 24'(d), 24'(x));
	endtask
	initial
	begin
		repeat (10) @(posedge clk_sys);
		#1 srst = 1'b0;
		rchk(4'h1, 16'h0000);
		i_host.wr(4'h1, 16'hffff);
		rchk(4'h1, 16'hc3c0);
		i_host.wr(4'h3, 16'h1234);
		rchk(4'h1, 16'hc3c0);
		rchk(4'h2, 16'h0000);
		$display("test access done");
		// every code of every field, ranges folding 3 to 0
		for (int i = 0; i < 16; i++)
		begin
			i_host.wr(4'h1, {i[1:0], i[3:0], i[3:0], {3{i[1:0]}}});
			rr = (i[1:0] == 2'h3) ? 2'h0 : i[1:0];
			rchk(4'h1, {i[1:0], (i > 9) ? 4'h0 : i[3:0], i[3:0], rr, rr, rr});
			chk("x_range", 24'(setup.x_range), 24'(rr));
			chk("dwell", cfg.dwell_cycles, 24'(ms[i] * 10000));
			chk("angle", 24'(cfg.angle_on), 24'(i[1:0] != 2'h0));
			chk("axes", 24'(cfg.angle_axes), 24'(ax[i[1:0]]));
			chk("seq", 24'({cfg.seq_len, cfg.seq_axes}), 24'(sq[i]));
		end
		$display("test fields done");
		for (int p = 0; p < 8; p++)
		begin
			power_state = p[2:0];
			@(posedge clk_sys) #1 chk("dwell_active", 24'(cfg.dwell_active), 24'(p == 2));
		end
		$display("test power done");
		// a reset in mid-run clears the stored word and returns the dwell decode to one millisecond
		i_host.wr(4'h1, 16'h4a95);
		@(posedge clk_sys) #1 srst = 1'b1;
		@(posedge clk_sys) #1 srst = 1'b0;
		chk("setup", 24'(setup), 24'h0);
		chk("dwell", cfg.dwell_cycles, 24'(10000));
		rchk(4'h1, 16'h0000);
		$display("test reset done");
		stop_test();
	end
	// whole run is near 100 cycles; fifteen times that means a hang
	initial
	begin
		#150000;
		errors++;
		stop_test();
	end
endmodule
